// [shared/jtmm_cfg.svh]
// Offsets, field positions, reset values and limits of the transport mapper
`ifndef JTMM_CFG_SVH
`define JTMM_CFG_SVH

// ======================================================================
// Register offsets (word index on the plain register port)
`define JTMM_REG_MODE 4'h0
`define JTMM_REG_KM1 4'h1
`define JTMM_REG_DEVNUM 4'h2
`define JTMM_REG_THR0 4'h3
`define JTMM_REG_THR1 4'h4
`define JTMM_REG_STATUS 4'h5
`define JTMM_REG_KEFF 4'h6
`define JTMM_REG_LANES 4'h7
`define JTMM_REG_FRAMES 4'h8

// ======================================================================
// Reset values
`define JTMM_RST_MODE 8'h3b
`define JTMM_RST_KM1 8'h0f
`define JTMM_RST_DEVNUM 8'h00
`define JTMM_RST_THR0 8'hff
`define JTMM_RST_THR1 8'hff

// ======================================================================
// Status register fields
`define JTMM_ST_MODEOK 0
`define JTMM_ST_KOK 1
`define JTMM_ST_ENC64 2
`define JTMM_ST_DUAL 3
`define JTMM_ST_LANES_LSB 4
`define JTMM_ST_OCT_LSB 8
`define JTMM_ST_DLOG_LSB 12

// ======================================================================
// Multiframe limits and link geometry
`define JTMM_K8_MIN 9'h008
`define JTMM_K16_MIN 9'h010
`define JTMM_K_MAX 9'h100
`define JTMM_K_STEP4 4'h4
`define JTMM_K_STEP8 4'h8
`define JTMM_K_BASE 12'h100
`define JTMM_DDC_BITS 8'h10
`define JTMM_RAW_BITS 8'h0c

`endif

// [shared/jtmm_pkg.sv]
// Types shared by the transport mapper modules
package jtmm_pkg;
   typedef enum logic [0:0] {
      JTMM_ENC_8B10B = 1'b0,
      JTMM_ENC_64B66B = 1'b1
   } jtmm_enc_t;

   typedef enum logic [1:0] {
      JTMM_PATH_BYPASS = 2'b00,
      JTMM_PATH_DUAL = 2'b01,
      JTMM_PATH_SINGLE = 2'b10
   } jtmm_path_t;
endpackage : jtmm_pkg

// [src/jtmm_mode_table.sv]
// Decoder from the output mode code to the link parameters
`timescale 1ns/1ns
`default_nettype none
`include "jtmm_cfg.svh"
module jtmm_mode_table (
   // Selected mode
   input wire logic [7:0] modeCode,
   // Decoded parameters
   output var logic modeValid,
   output jtmm_pkg::jtmm_enc_t encoding,
   output jtmm_pkg::jtmm_path_t path,
   output var logic [3:0] lanes,
   output var logic [3:0] octets,
   output var logic [4:0] values,
   output var logic [2:0] decimLog2,
   output var logic [8:0] kMin,
   output var logic [3:0] kStep,
   output var logic [8:0] kMax
);
   localparam jtmm_pkg::jtmm_enc_t E8 = jtmm_pkg::JTMM_ENC_8B10B;
   localparam jtmm_pkg::jtmm_enc_t E64 = jtmm_pkg::JTMM_ENC_64B66B;
   localparam jtmm_pkg::jtmm_path_t PB = jtmm_pkg::JTMM_PATH_BYPASS;
   localparam jtmm_pkg::jtmm_path_t PD = jtmm_pkg::JTMM_PATH_DUAL;
   localparam jtmm_pkg::jtmm_path_t PS = jtmm_pkg::JTMM_PATH_SINGLE;

   // Values is the count of transported values per link per frame
   function automatic logic [41:0] row(
      input logic e, input logic [1:0] p, input logic [3:0] l,
      input logic [3:0] f, input logic [4:0] v, input logic [2:0] d,
      input logic [8:0] kn, input logic [3:0] ks, input logic [8:0] kx);
      row = {1'b1, e, p, l, f, v, d, kn, ks, kx};
   endfunction : row

   logic [41:0] r;
   always_comb begin
      case (modeCode)
         8'h1e: r = row(E64, PB, 4'h4, 4'h8, 5'h14, 3'h0, 9'h0, 4'h0, 9'h0);
         8'h1f: r = row(E64, PB, 4'h4, 4'h8, 5'h14, 3'h0, 9'h0, 4'h0, 9'h0);
         8'h3b: r = row(E64, PD, 4'h1, 4'h4, 5'h02, 3'h4, 9'h0, 4'h0, 9'h0);
         8'h3c: r = row(E64, PD, 4'h2, 4'h2, 5'h02, 3'h4, 9'h0, 4'h0, 9'h0);
         8'h3d: r = row(E8, PS, 4'h1, 4'h2, 5'h01, 3'h4, `JTMM_K16_MIN,
                        `JTMM_K_STEP8, `JTMM_K_MAX);
         8'h3e: r = row(E8, PS, 4'h2, 4'h2, 5'h02, 3'h4, `JTMM_K16_MIN,
                        `JTMM_K_STEP8, `JTMM_K_MAX);
         8'h3f: r = row(E8, PS, 4'h4, 4'h2, 5'h04, 3'h4, `JTMM_K16_MIN,
                        `JTMM_K_STEP8, `JTMM_K_MAX);
         8'h40: r = row(E64, PS, 4'h1, 4'h2, 5'h01, 3'h4, 9'h0, 4'h0, 9'h0);
         8'h41: r = row(E64, PS, 4'h2, 4'h2, 5'h02, 3'h4, 9'h0, 4'h0, 9'h0);
         8'h42: r = row(E8, PD, 4'h1, 4'h4, 5'h02, 3'h5, `JTMM_K8_MIN,
                        `JTMM_K_STEP4, `JTMM_K_MAX);
         8'h43: r = row(E8, PD, 4'h2, 4'h2, 5'h02, 3'h5, `JTMM_K16_MIN,
                        `JTMM_K_STEP8, `JTMM_K_MAX);
         8'h44: r = row(E64, PD, 4'h1, 4'h4, 5'h02, 3'h5, 9'h0, 4'h0, 9'h0);
         8'h45: r = row(E8, PS, 4'h1, 4'h2, 5'h01, 3'h5, `JTMM_K16_MIN,
                        `JTMM_K_STEP8, `JTMM_K_MAX);
         8'h46: r = row(E8, PS, 4'h2, 4'h2, 5'h02, 3'h5, `JTMM_K16_MIN,
                        `JTMM_K_STEP8, `JTMM_K_MAX);
         8'h47: r = row(E64, PS, 4'h1, 4'h2, 5'h01, 3'h5, 9'h0, 4'h0, 9'h0);
         default: r = 42'h0;
      endcase
   end

   assign modeValid = r[41];
   assign encoding = jtmm_pkg::jtmm_enc_t'(r[40]);
   assign path = jtmm_pkg::jtmm_path_t'(r[39:38]);
   assign lanes = r[37:34];
   assign octets = r[33:30];
   assign values = r[29:25];
   assign decimLog2 = r[24:22];
   assign kMin = r[21:13];
   assign kStep = r[12:9];
   assign kMax = r[8:0];
endmodule : jtmm_mode_table
`default_nettype wire

// [src/jtmm_mapper.sv]
// Transport mapper: mode selection, lane plan and frame packing
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "jtmm_cfg.svh"
module jtmm_mapper (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   // Sample input, one strobe per sample instant
   input wire logic sampleValid,
   input wire logic [11:0] rawA,
   input wire logic [11:0] rawB,
   input wire logic [14:0] ddcAI,
   input wire logic [14:0] ddcAQ,
   input wire logic [14:0] ddcBI,
   input wire logic [14:0] ddcBQ,
   // Lane outputs, lanes 0-7 link A, 8-15 link B
   output logic [15:0][63:0] laneFrame,
   output logic frameValid,
   output logic multiframeEnd,
   output logic [15:0] laneEnable,
   output logic [15:0][2:0] laneNumber,
   output logic [7:0] linkADeviceNumber,
   output logic [7:0] linkBDeviceNumber,
   // Active link parameters
   output logic modeValid,
   output logic encoding64,
   output logic [3:0] lanesPerLink,
   output logic [3:0] octetsPerFrame,
   output logic [8:0] multiframeLength
);
   // ===================================================================
   // State
   typedef struct packed {
      logic [7:0] modeCode;
      logic [7:0] km1;
      logic [7:0] devNum;
      logic [7:0] thr0;
      logic [7:0] thr1;
      logic [15:0] rdData;
      logic [1:0][4:0] valCount;
      logic [1:0][7:0][63:0] collect;
      logic [15:0][63:0] laneFrame;
      logic frameValid;
      logic multiframeEnd;
      logic [8:0] frameCount;
      logic [15:0] frameTotal;
      logic [15:0] laneEnable;
      logic [15:0][2:0] laneNumber;
      logic [7:0] devA;
      logic [7:0] devB;
      logic modeOk;
      logic kOk;
      logic enc64;
      logic dual;
      logic [3:0] lanes;
      logic [3:0] octets;
      logic [2:0] dlog;
      logic [8:0] kEff;
   } jtmm_state_t;

   jtmm_state_t st;
   jtmm_state_t next_st;

   // ===================================================================
   // Mode decode
   logic tOk;
   jtmm_pkg::jtmm_enc_t tEnc;
   jtmm_pkg::jtmm_path_t tPath;
   logic [3:0] tLanes;
   logic [3:0] tOct;
   logic [4:0] tValues;
   logic [2:0] tDlog;
   logic [8:0] tKMin;
   logic [3:0] tKStep;
   logic [8:0] tKMax;

   jtmm_mode_table modeTable (
      .modeCode(st.modeCode),
      .modeValid(tOk),
      .encoding(tEnc),
      .path(tPath),
      .lanes(tLanes),
      .octets(tOct),
      .values(tValues),
      .decimLog2(tDlog),
      .kMin(tKMin),
      .kStep(tKStep),
      .kMax(tKMax)
   );

   // ===================================================================
   // Helpers
   // Top eight magnitude bits of a signed 15-bit value
   function automatic logic [7:0] magTop(input logic [14:0] s);
      logic [14:0] a;
      a = s[14] ? 15'(~s + 15'h1) : s;
      magTop = a[14:7];
   endfunction : magTop

   // Larger of |I| and |Q| stands in for the complex magnitude
   function automatic logic over(input logic [14:0] i,
                                 input logic [14:0] q,
                                 input logic [7:0] thr);
      logic [7:0] mi;
      logic [7:0] mq;
      mi = magTop(i);
      mq = magTop(q);
      over = ((mi > mq) ? mi : mq) > thr;
   endfunction : over

   // OR a left-aligned 16-bit value into its slot, first slot at the top
   function automatic logic [63:0] place(input logic [63:0] w,
                                         input logic [2:0] slot,
                                         input logic raw,
                                         input logic [15:0] v);
      logic [7:0] width;
      logic [7:0] sh;
      width = raw ? `JTMM_RAW_BITS : `JTMM_DDC_BITS;
      sh = 8'({5'h0, slot} * width);
      place = w | ({v, 48'h0} >> sh);
   endfunction : place

   // Derived multiframe length for 64b/66b
   function automatic logic [8:0] kDerive(input logic [3:0] f);
      kDerive = (f == 4'h0) ? 9'h0 : 9'(`JTMM_K_BASE / {8'h0, f});
   endfunction : kDerive

   // ===================================================================
   // Next state
   logic [8:0] kProg;
   logic kInRange;
   logic [1:0][1:0][15:0] linkVal;
   logic [1:0] linkCount;
   logic ovrA0;
   logic ovrA1;
   logic ovrB0;
   logic ovrB1;
   logic isRaw;

   always_comb begin
      logic [4:0] idx;
      logic [2:0] lane;
      logic [2:0] slot;
      logic done;
      idx = 5'h0;
      lane = 3'h0;
      slot = 3'h0;
      done = 1'b0;
      next_st = st;
      next_st.frameValid = 1'b0;
      next_st.multiframeEnd = 1'b0;

      // Register access
      next_st.rdData = 16'h0;
      if (regRead) begin
         case (regAddr)
            `JTMM_REG_MODE: next_st.rdData = {8'h0, st.modeCode};
            `JTMM_REG_KM1: next_st.rdData = {8'h0, st.km1};
            `JTMM_REG_DEVNUM: next_st.rdData = {8'h0, st.devNum};
            `JTMM_REG_THR0: next_st.rdData = {8'h0, st.thr0};
            `JTMM_REG_THR1: next_st.rdData = {8'h0, st.thr1};
            `JTMM_REG_STATUS: begin
               next_st.rdData[`JTMM_ST_MODEOK] = st.modeOk;
               next_st.rdData[`JTMM_ST_KOK] = st.kOk;
               next_st.rdData[`JTMM_ST_ENC64] = st.enc64;
               next_st.rdData[`JTMM_ST_DUAL] = st.dual;
               next_st.rdData[`JTMM_ST_LANES_LSB +: 4] = st.lanes;
               next_st.rdData[`JTMM_ST_OCT_LSB +: 4] = st.octets;
               next_st.rdData[`JTMM_ST_DLOG_LSB +: 3] = st.dlog;
            end
            `JTMM_REG_KEFF: next_st.rdData = {7'h0, st.kEff};
            `JTMM_REG_LANES: next_st.rdData = st.laneEnable;
            `JTMM_REG_FRAMES: next_st.rdData = st.frameTotal;
            default: next_st.rdData = 16'h0;
         endcase
      end
      if (regWrite) begin
         case (regAddr)
            `JTMM_REG_MODE: next_st.modeCode = regWrData[7:0];
            `JTMM_REG_KM1: next_st.km1 = regWrData[7:0];
            `JTMM_REG_DEVNUM: next_st.devNum = regWrData[7:0];
            `JTMM_REG_THR0: next_st.thr0 = regWrData[7:0];
            `JTMM_REG_THR1: next_st.thr1 = regWrData[7:0];
            default: ;
         endcase
      end

      // Registered copy of the decoded parameters
      next_st.modeOk = tOk;
      next_st.enc64 = (tEnc == jtmm_pkg::JTMM_ENC_64B66B);
      next_st.dual = (tPath == jtmm_pkg::JTMM_PATH_DUAL);
      next_st.lanes = tLanes;
      next_st.octets = tOct;
      next_st.dlog = tDlog;
      // Out-of-range K falls back to the mode minimum and is flagged
      if (tEnc == jtmm_pkg::JTMM_ENC_64B66B) begin
         next_st.kEff = kDerive(tOct);
         next_st.kOk = tOk;
      end else begin
         next_st.kEff = kInRange ? kProg : tKMin;
         next_st.kOk = tOk && kInRange;
      end

      // Both links run the same lane count; unused upper lanes are off
      for (int l = 0; l < 2; l++) begin
         for (int k = 0; k < 8; k++) begin
            next_st.laneEnable[l * 8 + k] = tOk && (4'(k) < tLanes);
            next_st.laneNumber[l * 8 + k] = 3'(k);
         end
      end
      next_st.devA = st.devNum;
      next_st.devB = 8'(st.devNum + 8'h1);

      // Frame assembly; a mode change restarts both collectors
      if (regWrite && regAddr == `JTMM_REG_MODE) begin
         next_st.valCount = '0;
         next_st.collect = '0;
         next_st.frameCount = 9'h0;
      end else if (sampleValid && tOk) begin
         for (int l = 0; l < 2; l++) begin
            for (int j = 0; j < 2; j++) begin
               if (2'(j) < linkCount) begin
                  idx = 5'(next_st.valCount[l] + 5'(j));
                  lane = 3'(idx % {1'b0, tLanes});
                  slot = 3'(idx / {1'b0, tLanes});
                  next_st.collect[l][lane] =
                     place(next_st.collect[l][lane], slot, isRaw,
                           linkVal[l][j]);
               end
            end
            idx = 5'(st.valCount[l] + {3'h0, linkCount});
            done = (idx >= tValues);
            if (done) begin
               for (int k = 0; k < 8; k++) begin
                  next_st.laneFrame[l * 8 + k] = next_st.collect[l][k];
               end
               next_st.collect[l] = '0;
               next_st.valCount[l] = 5'h0;
            end else begin
               next_st.valCount[l] = idx;
            end
            if (l == 0 && done) begin
               next_st.frameValid = 1'b1;
               next_st.frameTotal = 16'(st.frameTotal + 16'h1);
               if (st.frameCount + 9'h1 >= st.kEff) begin
                  next_st.frameCount = 9'h0;
                  next_st.multiframeEnd = 1'b1;
               end else begin
                  next_st.frameCount = 9'(st.frameCount + 9'h1);
               end
            end
         end
      end
      if (!tOk) begin
         next_st.laneFrame = '0;
      end
   end

   // ===================================================================
   // Value selection per link
   assign kProg = 9'({1'b0, st.km1} + 9'h1);
   assign kInRange = (kProg >= tKMin) && (kProg <= tKMax) &&
                     (((kProg - tKMin) & 9'({5'h0, tKStep} - 9'h1)) == 9'h0);
   assign isRaw = (tPath == jtmm_pkg::JTMM_PATH_BYPASS);
   assign ovrA0 = over(ddcAI, ddcAQ, st.thr0);
   assign ovrA1 = over(ddcAI, ddcAQ, st.thr1);
   assign ovrB0 = over(ddcBI, ddcBQ, st.thr0);
   assign ovrB1 = over(ddcBI, ddcBQ, st.thr1);

   always_comb begin
      linkVal = '0;
      linkCount = 2'h1;
      case (tPath)
         jtmm_pkg::JTMM_PATH_DUAL: begin
            // Link A carries DDC A, link B carries DDC B
            linkVal[0][0] = {ddcAI, ovrA0};
            linkVal[0][1] = {ddcAQ, ovrA1};
            linkVal[1][0] = {ddcBI, ovrB0};
            linkVal[1][1] = {ddcBQ, ovrB1};
            linkCount = 2'h2;
         end
         jtmm_pkg::JTMM_PATH_SINGLE: begin
            // I stream on link A, Q stream on link B
            linkVal[0][0] = {ddcAI, ovrA0};
            linkVal[1][0] = {ddcAQ, ovrA1};
         end
         jtmm_pkg::JTMM_PATH_BYPASS: begin
            // Both bypass codes: link A carries raw channel A, link B raw channel B
            linkVal[0][0] = {rawA, 4'h0};
            linkVal[1][0] = {rawB, 4'h0};
         end
         default: linkCount = 2'h0;
      endcase
   end

   // ===================================================================
   // Registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st <= '0;
         st.modeCode <= `JTMM_RST_MODE;
         st.km1 <= `JTMM_RST_KM1;
         st.devNum <= `JTMM_RST_DEVNUM;
         st.thr0 <= `JTMM_RST_THR0;
         st.thr1 <= `JTMM_RST_THR1;
      end else begin
         st <= next_st;
      end
   end

   // ===================================================================
   // Outputs
   assign regRdData = st.rdData;
   assign laneFrame = st.laneFrame;
   assign frameValid = st.frameValid;
   assign multiframeEnd = st.multiframeEnd;
   assign laneEnable = st.laneEnable;
   assign laneNumber = st.laneNumber;
   assign linkADeviceNumber = st.devA;
   assign linkBDeviceNumber = st.devB;
   assign modeValid = st.modeOk;
   assign encoding64 = st.enc64;
   assign lanesPerLink = st.lanes;
   assign octetsPerFrame = st.octets;
   assign multiframeLength = st.kEff;
endmodule : jtmm_mapper
`default_nettype wire

// [dv/jtmm_rx_model.sv]
// Receiver model that rebuilds time order of the first link A values
`timescale 1ns/1ns
`default_nettype none
module jtmm_rx_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Link A lanes 0 and 1
   input wire logic frameValid,
   input wire logic [63:0] laneA0,
   input wire logic [63:0] laneA1,
   // Lanes per link, set to match the transmitter
   input wire logic [3:0] cfgLanes,
   // First two values of the last frame, in time order
   output logic [15:0] rxFirst,
   output logic [15:0] rxSecond
);
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rxFirst <= 16'h0000;
         rxSecond <= 16'h0000;
      end else if (frameValid) begin
         rxFirst <= laneA0[63:48];
         // One lane holds both values; wider links spread them over lanes
         rxSecond <= (cfgLanes == 4'h1) ? laneA0[47:32] : laneA1[63:48];
      end
   end
endmodule : jtmm_rx_model
`default_nettype wire

// [dv/jtmm_mapper_asserts.sv]
// Port checks for the transport mapper
`timescale 1ns/1ns
`default_nettype none
module jtmm_mapper_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register and sample side
   input wire logic regRead,
   input wire logic [15:0] regRdData,
   input wire logic sampleValid,
   // Lane side
   input wire logic frameValid,
   input wire logic multiframeEnd,
   input wire logic [15:0] laneEnable,
   input wire logic [15:0][2:0] laneNumber,
   input wire logic [7:0] linkADeviceNumber,
   input wire logic [7:0] linkBDeviceNumber,
   input wire logic modeValid,
   input wire logic encoding64,
   input wire logic [3:0] lanesPerLink,
   input wire logic [3:0] octetsPerFrame,
   input wire logic [8:0] multiframeLength
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ====
   // Sequences
   sequence awake;
      !$past(sys_rst);
   endsequence
   sequence steady;
      modeValid && !$past(sys_rst) && $stable(lanesPerLink) && $stable(modeValid);
   endsequence
   sequence idleMode;
      !$past(sys_rst) ##1 !modeValid ##1 !modeValid;
   endsequence
   // ====
   // Assertions
   a_mf_in_frame:
      assert property (multiframeEnd |-> frameValid)
      else $error("Multiframe end without a frame");
   a_frame_cause:
      assert property (frameValid |-> $past(sampleValid))
      else $error("Frame without a sample strobe");
   a_read_idle:
      assert property (!regRead |=> regRdData == 16'h0000)
      else $error("Read data outside the read window");
   a_link_b_num:
      assert property (awake |-> linkBDeviceNumber == linkADeviceNumber + 8'h01)
      else $error("Link B device number not A plus one");
   a_lane_ids:
      assert property (awake |-> laneNumber == {2{24'hfac688}})
      else $error("Lane numbers do not follow lane index");
   a_both_links:
      assert property (awake |-> laneEnable[15:8] == laneEnable[7:0])
      else $error("Links use different lane sets");
   a_low_lanes:
      assert property (steady |-> laneEnable[7:0] == (8'h01 << lanesPerLink) - 8'h01)
      else $error("Enabled lanes are not the lowest ones");
   a_k_derived:
      assert property (modeValid && encoding64 |->
         13'(multiframeLength) * 13'(octetsPerFrame) == 13'h0100)
      else $error("Derived multiframe length wrong");
   a_k_window:
      assert property (modeValid && !encoding64 |-> multiframeLength inside
         {[9'h008:9'h100]} && multiframeLength[1:0] == 2'b00)
      else $error("Multiframe length out of range");
   a_dead_lanes:
      assert property (idleMode |-> laneEnable == 16'h0000)
      else $error("Lanes enabled in an invalid mode");
endmodule : jtmm_mapper_asserts

bind jtmm_mapper jtmm_mapper_asserts jtmm_mapper_asserts_i (
   .mclk(mclk), .sys_rst(sys_rst), .regRead(regRead),
   .regRdData(regRdData), .sampleValid(sampleValid),
   .frameValid(frameValid), .multiframeEnd(multiframeEnd),
   .laneEnable(laneEnable), .laneNumber(laneNumber),
   .linkADeviceNumber(linkADeviceNumber),
   .linkBDeviceNumber(linkBDeviceNumber), .modeValid(modeValid),
   .encoding64(encoding64), .lanesPerLink(lanesPerLink),
   .octetsPerFrame(octetsPerFrame), .multiframeLength(multiframeLength)
);
`default_nettype wire

// [dv/jtmm_mapper_bench.sv]
// Self-checking bench for the transport mapper
`timescale 1ns/1ns
`default_nettype none
module jtmm_mapper_bench;
   logic mclk, sys_rst, regWrite, regRead, sampleValid;
   logic [3:0] regAddr, lanesPerLink, octetsPerFrame, rxLanes;
   logic [15:0] regWrData, regRdData, laneEnable, rxFirst, rxSecond;
   logic [11:0] rawA, rawB;
   logic [14:0] ddcAI, ddcAQ, ddcBI, ddcBQ;
   logic [15:0][63:0] laneFrame;
   logic frameValid, multiframeEnd, modeValid, encoding64;
   logic [15:0][2:0] laneNumber;
   logic [7:0] linkADeviceNumber, linkBDeviceNumber;
   logic [8:0] multiframeLength;
   int n_errors = 0;
   int compares = 0;
   // {lanes, encoding, octets} for codes 59 to 71
   localparam logic [11:0] MT [13] = '{12'h114, 12'h212, 12'h102, 12'h202,
      12'h402, 12'h112, 12'h212, 12'h104, 12'h202, 12'h114, 12'h102,
      12'h202, 12'h112};
   // {accepted, length, written value}
   localparam logic [17:0] KT [5] = '{18'h20807, 18'h20c0b, 18'h300ff,
      18'h00805, 18'h00808};
   // {address, reset value}
   localparam logic [19:0] RT [8] = '{20'h0003b, 20'h1000f, 20'h20000,
      20'h300ff, 20'h400ff, 20'h60040, 20'h70101, 20'hf0000};

   jtmm_mapper jtmm_mapper_i (.mclk(mclk), .sys_rst(sys_rst),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData), .sampleValid(sampleValid),
      .rawA(rawA), .rawB(rawB), .ddcAI(ddcAI), .ddcAQ(ddcAQ),
      .ddcBI(ddcBI), .ddcBQ(ddcBQ), .laneFrame(laneFrame),
      .frameValid(frameValid), .multiframeEnd(multiframeEnd),
      .laneEnable(laneEnable), .laneNumber(laneNumber),
      .linkADeviceNumber(linkADeviceNumber),
      .linkBDeviceNumber(linkBDeviceNumber), .modeValid(modeValid),
      .encoding64(encoding64), .lanesPerLink(lanesPerLink),
      .octetsPerFrame(octetsPerFrame), .multiframeLength(multiframeLength));
   jtmm_rx_model jtmm_rx_model_i (.mclk(mclk), .sys_rst(sys_rst),
      .frameValid(frameValid), .laneA0(laneFrame[0]),
      .laneA1(laneFrame[1]), .cfgLanes(rxLanes), .rxFirst(rxFirst),
      .rxSecond(rxSecond));

   always #25 mclk = ~mclk;

   // ====
   // Helpers
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task automatic regWr(input logic [3:0] a, input logic [15:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
      // Let an edge pass so a following write always re-raises the strobe
      @(posedge mclk);
   endtask : regWr
   // Data stand only in the cycle after the strobe, so take them there
   task automatic regRd(input logic [3:0] a, output logic [15:0] d);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      @(posedge mclk);
      d = regRdData;
   endtask : regRd
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   // ====
   // Scenarios
   task automatic t_reset();
      logic [15:0] d;
      foreach (RT[i]) begin
         regRd(RT[i][19:16], d);
         chk(d, RT[i][15:0]);
      end
      regWr(4'h7, 16'h1234);
      regWr(4'h2, 16'h00ff);
      tick(2);
      chk(linkADeviceNumber, 8'hff);
      chk(linkBDeviceNumber, 8'h00);
      regRd(4'h7, d);
      chk(d, 16'h0101);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_modes();
      logic [11:0] e;
      for (int i = 0; i < 13; i++) begin
         e = MT[i];
         regWr(4'h0, 16'h003b + 16'(i));
         tick(2);
         chk(lanesPerLink, e[11:8]);
         chk(encoding64, e[4]);
         chk(octetsPerFrame, e[3:0]);
         chk(laneEnable, {2{8'((8'h01 << e[11:8]) - 8'h01)}});
         chk(multiframeLength, e[4] ? 9'h100 / e[3:0] : 9'h010);
      end
      regWr(4'h0, 16'h0048);
      tick(2);
      chk(modeValid, 1'b0);
      chk(laneEnable, 16'h0000);
      $display("t_modes done");
   endtask : t_modes
   task automatic t_kprog();
      logic [15:0] st;
      regWr(4'h0, 16'h0042);
      foreach (KT[i]) begin
         regWr(4'h1, {8'h00, KT[i][7:0]});
         tick(2);
         chk(multiframeLength, KT[i][16:8]);
         regRd(4'h5, st);
         chk(st[1], KT[i][17]);
      end
      regWr(4'h0, 16'h003d);
      tick(2);
      chk(multiframeLength, 9'h010);
      regWr(4'h0, 16'h0040);
      tick(2);
      chk(multiframeLength, 9'h080);
      $display("t_kprog done");
   endtask : t_kprog
   task automatic t_ddc();
      regWr(4'h3, 16'h0010);
      regWr(4'h4, 16'h007e);
      regWr(4'h0, 16'h003b);
      rxLanes <= 4'h1;
      ddcAI <= 15'h3f00;
      ddcAQ <= 15'h0100;
      ddcBI <= 15'h0005;
      ddcBQ <= 15'h7ffb;
      sampleValid <= 1'b1;
      for (int i = 0; i <= 64; i++) begin
         @(posedge mclk);
         if (i == 63) sampleValid <= 1'b0;
         if (i > 0) chk(multiframeEnd, 1'(i == 64));
         if (i == 1) chk(laneFrame[0], {16'h7e01, 16'h0200, 32'h0});
         if (i == 1) chk(laneFrame[8], {16'h000a, 16'hfff6, 32'h0});
         if (i == 2) chk({rxFirst, rxSecond}, 32'h7e010200);
      end
      regWr(4'h0, 16'h003e);
      rxLanes <= 4'h2;
      ddcAI <= 15'h0123;
      sampleValid <= 1'b1;
      @(posedge mclk);
      ddcAI <= 15'h0456;
      @(posedge mclk);
      sampleValid <= 1'b0;
      tick(2);
      chk({rxFirst, rxSecond}, 32'h024608ac);
      chk(laneFrame[8][63:48], 16'h0200);
      $display("t_ddc done");
   endtask : t_ddc
   task automatic t_bypass();
      regWr(4'h0, 16'h001e);
      rawA <= 12'hbad;
      sampleValid <= 1'b1;
      tick(3);
      sampleValid <= 1'b0;
      regWr(4'h0, 16'h001f);
      for (int v = 0; v < 20; v++) begin
         rawA <= 12'h100 + 12'(v);
         rawB <= 12'h200 + 12'(v);
         sampleValid <= 1'b1;
         @(posedge mclk);
      end
      sampleValid <= 1'b0;
      @(posedge mclk);
      chk(frameValid, 1'b1);
      chk(laneFrame[0], {48'h10010410810c, 12'h110, 4'h0});
      chk(laneFrame[11], {48'h20320720b20f, 12'h213, 4'h0});
      $display("t_bypass done");
   endtask : t_bypass

   initial begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      {regWrite, regRead, sampleValid} = 3'h0;
      regAddr = 4'h0;
      regWrData = 16'h0000;
      {rawA, rawB} = 24'h000000;
      {ddcAI, ddcAQ, ddcBI, ddcBQ} = 60'h0;
      rxLanes = 4'h1;
      tick(2);
      sys_rst <= 1'b0;
      tick(2);
      t_reset();
      t_modes();
      t_kprog();
      t_ddc();
      t_bypass();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      final_report();
   end
endmodule : jtmm_mapper_bench
`default_nettype wire
